// *** cclx_regs.svh ***
// timing counts, pin indices and fixed values for the caption line extractor
// assumes a 20 MHz master clock; included by bare name
// Behaviour
// - two straps select one of four modes
// - modes 1-2 capture line 21, even field
// - mode 3 captures line 21, both fields
// - mode 4 captures line 22, both fields
// - mode 2 references resonator divided by 32
// - mode 1 locks to separated hsync
// - modes 3-4 lock to external flyback hsync
// - shared sync pin role follows mode
// - shared field pin role follows mode
// - line marker per mode and field
// - serial out released while select high
// - bits change after transfer clock falls
// - modes 1-2 buffer once per frame
// - second read before the next load gives zeros
// - no buffer load while select low
`ifndef CCLX_REGS_SVH
`define CCLX_REGS_SVH

// ----------------------------------------------------------------------------
// clock and video timing
// ----------------------------------------------------------------------------
`define CCLX_MCLK_NS 50
`define CCLX_LINE_NS 63556
`define CCLX_LINE_CYC (`CCLX_LINE_NS / `CCLX_MCLK_NS)
`define CCLX_ACCEPT_CYC ((`CCLX_LINE_CYC * 3) / 4)
`define CCLX_HALF_CYC (`CCLX_LINE_CYC / 2)
`define CCLX_VS_MIN_NS 20000
`define CCLX_VS_MIN_CYC ((`CCLX_VS_MIN_NS + `CCLX_MCLK_NS - 1) / `CCLX_MCLK_NS)
`define CCLX_HS_PULSE_NS 4700
`define CCLX_HS_PULSE_CYC (`CCLX_HS_PULSE_NS / `CCLX_MCLK_NS)
`define CCLX_FIRST_BIT_NS 49200
`define CCLX_FIRST_BIT_CYC (`CCLX_FIRST_BIT_NS / `CCLX_MCLK_NS)
`define CCLX_BIT_NS 1986
`define CCLX_BIT_CYC (`CCLX_BIT_NS / `CCLX_MCLK_NS)

// ----------------------------------------------------------------------------
// lines, divider, widths
// ----------------------------------------------------------------------------
`define CCLX_LINE_NTSC 10'h015
`define CCLX_LINE_PAL 10'h016
`define CCLX_VS_LINE 10'h004
`define CCLX_OSC_DIV_LAST 5'h1F
`define CCLX_WORD_BITS 5'h10
`define CCLX_FIFO_DEPTH 8

// ----------------------------------------------------------------------------
// synchroniser bit positions and reset pattern
// ----------------------------------------------------------------------------
`define CCLX_S_STRAP_LO 0
`define CCLX_S_STRAP_HI 1
`define CCLX_S_CSYNC_N 2
`define CCLX_S_SLICE 3
`define CCLX_S_HSOSC 4
`define CCLX_S_SCLK 5
`define CCLX_S_CS_N 6
`define CCLX_SYNC_RST 7'h74

`endif

// *** cclx_pkg.sv ***
// types shared by the caption line extractor files
// assumes cclx_regs.svh holds the numeric constants
package cclx_pkg;

    typedef enum logic [1:0] {MODE_1, MODE_2, MODE_3, MODE_4} cclx_mode_t;

    typedef enum logic [1:0] {CAP_IDLE, CAP_SAMPLE, CAP_PUSH} cclx_cap_t;

    typedef struct packed {
        logic [7:0] second;
        logic [7:0] first;
    } cclx_word_t;

    typedef struct packed {
        logic o;
        logic oe_n;
    } cclx_pad_t;

endpackage

// *** cclx_fifo.sv ***
// small synchronous fifo between line capture and the output buffer
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module cclx_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign o_in_ready = (count_r != (AW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data = mem_r[rd_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == (AW)'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge i_mclk)
    begin
        if (push)
        begin
            mem_r[wr_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_r <= '0;
            rd_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_r <= wrap_inc(wr_r);
            end
            if (pop)
            begin
                rd_r <= wrap_inc(rd_r);
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** cclx_top.sv ***
// caption line extractor: line timing, capture, buffering, serial read-out
// assumes sliced video levels and all pins arrive asynchronous to i_mclk
`timescale 1ns/10ps
`default_nettype none
`include "cclx_regs.svh"

module cclx_top
    import cclx_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_mode_strap_low,
    input wire logic i_mode_strap_high,
    input wire logic i_composite_video_in_sync_n,
    input wire logic i_composite_video_in_slice,
    input wire logic i_hsync_or_osc_in,
    output cclx_pad_t o_hsync_or_osc_in_pad,
    output logic o_field_parity_or_osc_out,
    output logic o_line_marker_pulse,
    input wire logic i_transfer_clock_in,
    input wire logic i_chip_select_n,
    output cclx_pad_t o_caption_serial_out_pad
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    function automatic cclx_mode_t mode_of(input logic hi, input logic lo);
        case ({hi, lo})
            2'b00: mode_of = MODE_1;
            2'b01: mode_of = MODE_2;
            2'b10: mode_of = MODE_3;
            default: mode_of = MODE_4;
        endcase
    endfunction

    function automatic logic [9:0] target_line(input cclx_mode_t m);
        target_line = (m == MODE_4) ? `CCLX_LINE_PAL : `CCLX_LINE_NTSC;
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [6:0] meta_r;
    logic [6:0] sync_r;
    logic [6:0] prev_r;
    logic [6:0] raw;

    assign raw = {i_chip_select_n, i_transfer_clock_in, i_hsync_or_osc_in,
                  i_composite_video_in_slice, i_composite_video_in_sync_n,
                  i_mode_strap_high, i_mode_strap_low};

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_r <= `CCLX_SYNC_RST;
            sync_r <= `CCLX_SYNC_RST;
            prev_r <= `CCLX_SYNC_RST;
        end
        else
        begin
            meta_r <= raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic hs_pin;
    logic cs_n;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic osc_rise;
    logic hs_fall;
    logic sep_fall;

    assign hs_pin = sync_r[`CCLX_S_HSOSC];
    assign cs_n = sync_r[`CCLX_S_CS_N];
    assign cs_fall = !cs_n && prev_r[`CCLX_S_CS_N];
    assign cs_rise = cs_n && !prev_r[`CCLX_S_CS_N];
    assign sclk_fall = !sync_r[`CCLX_S_SCLK] && prev_r[`CCLX_S_SCLK];
    assign osc_rise = hs_pin && !prev_r[`CCLX_S_HSOSC];
    assign hs_fall = !hs_pin && prev_r[`CCLX_S_HSOSC];
    assign sep_fall = !sync_r[`CCLX_S_CSYNC_N] && prev_r[`CCLX_S_CSYNC_N];

    // ------------------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------------------
    cclx_mode_t mode_r;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mode_r <= MODE_1;
        end
        else
        begin
            mode_r <= mode_of(sync_r[`CCLX_S_STRAP_HI], sync_r[`CCLX_S_STRAP_LO]);
        end
    end

    // ------------------------------------------------------------------------
    // line reference and line position
    // ------------------------------------------------------------------------
    // half-line equalising pulses are rejected by the acceptance window
    logic [4:0] div_r;
    logic [10:0] pos_r;
    logic late;
    logic osc_ref;
    logic ext_ref;
    logic sep_ref;
    logic ref_h;

    assign late = (pos_r >= 11'(`CCLX_ACCEPT_CYC));
    assign osc_ref = (mode_r == MODE_2) && osc_rise && (div_r == `CCLX_OSC_DIV_LAST);
    assign ext_ref = ((mode_r == MODE_3) || (mode_r == MODE_4)) && hs_fall && late;
    assign sep_ref = (mode_r == MODE_1) && sep_fall && late;
    assign ref_h = osc_ref || ext_ref || sep_ref;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_r <= 5'h00;
        end
        else if (mode_r != MODE_2)
        begin
            div_r <= 5'h00;
        end
        else if (osc_rise)
        begin
            div_r <= div_r + 5'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pos_r <= 11'h000;
        end
        else if (ref_h)
        begin
            pos_r <= 11'h000;
        end
        else if (pos_r != 11'h7FF)
        begin
            pos_r <= pos_r + 11'h001;
        end
    end

    // ------------------------------------------------------------------------
    // vertical detection, field parity, line count
    // ------------------------------------------------------------------------
    // broad pulse timing against the line phase tells the fields apart
    logic [10:0] low_cnt_r;
    logic vs_evt;
    logic field_even_r;
    logic [9:0] line_r;

    assign vs_evt = (low_cnt_r == 11'(`CCLX_VS_MIN_CYC));

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            low_cnt_r <= 11'h000;
        end
        else if (sync_r[`CCLX_S_CSYNC_N])
        begin
            low_cnt_r <= 11'h000;
        end
        else if (low_cnt_r != 11'h7FF)
        begin
            low_cnt_r <= low_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            field_even_r <= 1'b0;
            line_r <= 10'h000;
        end
        else if (vs_evt)
        begin
            field_even_r <= (pos_r >= 11'(`CCLX_HALF_CYC));
            line_r <= `CCLX_VS_LINE;
        end
        else if (ref_h && (line_r != 10'h3FF))
        begin
            line_r <= line_r + 10'h001;
        end
    end

    // ------------------------------------------------------------------------
    // caption capture
    // ------------------------------------------------------------------------
    logic on_target;
    logic cap_field_ok;
    cclx_cap_t cap_r;
    logic [10:0] bit_cnt_r;
    logic [4:0] bit_idx_r;
    logic [15:0] cap_word_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;

    assign on_target = (line_r == target_line(mode_r));
    assign cap_field_ok = ((mode_r == MODE_1) || (mode_r == MODE_2)) ? field_even_r : 1'b1;

    // a full fifo holds the word in CAP_PUSH, so the next line is skipped
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cap_r <= CAP_IDLE;
            bit_cnt_r <= 11'h000;
            bit_idx_r <= 5'h00;
            cap_word_r <= 16'h0000;
        end
        else
        begin
            case (cap_r)
                CAP_IDLE:
                begin
                    if (on_target && cap_field_ok && (pos_r == 11'(`CCLX_FIRST_BIT_CYC)))
                    begin
                        cap_r <= CAP_SAMPLE;
                        bit_cnt_r <= 11'h000;
                        bit_idx_r <= 5'h00;
                    end
                end
                CAP_SAMPLE:
                begin
                    if (bit_cnt_r == 11'h000)
                    begin
                        cap_word_r <= {sync_r[`CCLX_S_SLICE], cap_word_r[15:1]};
                        bit_cnt_r <= 11'(`CCLX_BIT_CYC - 1);
                        bit_idx_r <= bit_idx_r + 5'h01;
                        if (bit_idx_r == `CCLX_WORD_BITS - 5'h01)
                        begin
                            cap_r <= CAP_PUSH;
                        end
                    end
                    else
                    begin
                        bit_cnt_r <= bit_cnt_r - 11'h001;
                    end
                end
                CAP_PUSH:
                begin
                    if (fifo_in_ready)
                    begin
                        cap_r <= CAP_IDLE;
                    end
                end
                default:
                begin
                    cap_r <= CAP_IDLE;
                end
            endcase
        end
    end

    cclx_fifo #(
        .WIDTH(16),
        .DEPTH(`CCLX_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(cap_r == CAP_PUSH),
        .o_in_ready(fifo_in_ready),
        .i_in_data(cap_word_r),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    // ------------------------------------------------------------------------
    // output buffer and serial read-out
    // ------------------------------------------------------------------------
    cclx_word_t out_buf_r;
    logic fresh_r;
    logic [15:0] tx_r;
    logic [15:0] tx_nxt;
    logic [4:0] tx_cnt_r;
    cclx_pad_t caption_pad_r;

    assign fifo_out_ready = cs_n;

    always_comb
    begin
        tx_nxt = tx_r;
        if (cs_fall)
        begin
            tx_nxt = fresh_r ? out_buf_r : 16'h0000;
        end
        else if (sclk_fall && !cs_n)
        begin
            tx_nxt = {1'b0, tx_r[15:1]};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_r <= 16'h0000;
            tx_cnt_r <= 5'h00;
        end
        else
        begin
            tx_r <= tx_nxt;
            if (cs_fall)
            begin
                tx_cnt_r <= 5'h00;
            end
            else if (sclk_fall && !cs_n && (tx_cnt_r != `CCLX_WORD_BITS))
            begin
                tx_cnt_r <= tx_cnt_r + 5'h01;
            end
        end
    end

    // a completed read marks the buffer stale; a load in that cycle wins
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            out_buf_r <= 16'h0000;
            fresh_r <= 1'b0;
        end
        else if (fifo_out_valid && fifo_out_ready)
        begin
            out_buf_r <= fifo_out_data;
            fresh_r <= 1'b1;
        end
        else if (cs_rise && (tx_cnt_r == `CCLX_WORD_BITS))
        begin
            fresh_r <= 1'b0;
        end
    end

    // open drain: only a zero bit pulls the line
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            caption_pad_r <= 2'b01;
        end
        else
        begin
            caption_pad_r.o <= 1'b0;
            caption_pad_r.oe_n <= cs_n || tx_nxt[0];
        end
    end

    // ------------------------------------------------------------------------
    // shared pins and line marker
    // ------------------------------------------------------------------------
    cclx_pad_t hs_pad_r;
    logic field_out_r;
    logic marker_r;
    logic mark_field_ok;

    assign mark_field_ok = (mode_r == MODE_1) ? field_even_r : 1'b1;

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hs_pad_r <= 2'b11;
            field_out_r <= 1'b0;
            marker_r <= 1'b0;
        end
        else
        begin
            hs_pad_r.o <= !((mode_r == MODE_1) && (pos_r < 11'(`CCLX_HS_PULSE_CYC)));
            hs_pad_r.oe_n <= (mode_r != MODE_1);
            field_out_r <= (mode_r == MODE_2) ? !hs_pin : field_even_r;
            marker_r <= on_target && mark_field_ok;
        end
    end

    assign o_hsync_or_osc_in_pad = hs_pad_r;
    assign o_field_parity_or_osc_out = field_out_r;
    assign o_line_marker_pulse = marker_r;
    assign o_caption_serial_out_pad = caption_pad_r;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_mode_two;
        (sync_r[1:0] == 2'b01) |=> (mode_r == MODE_2);
    endproperty
    a_mode_two: assert property (p_mode_two) else $error("straps 01 did not give mode 2");

    property p_release;
        cs_n |=> caption_pad_r.oe_n;
    endproperty
    a_release: assert property (p_release) else $error("serial line driven while select high");

    property p_shift_cause;
        $changed(caption_pad_r.oe_n) |-> $past(sclk_fall || cs_fall || cs_rise);
    endproperty
    a_shift_cause: assert property (p_shift_cause) else $error("serial bit changed without clock edge");

    property p_stale_zero;
        (cs_fall && !fresh_r) |=> (tx_r == 16'h0000) && !caption_pad_r.oe_n;
    endproperty
    a_stale_zero: assert property (p_stale_zero) else $error("stale read not all zeros");

    property p_no_load_low;
        !cs_n |=> $stable(out_buf_r);
    endproperty
    a_no_load_low: assert property (p_no_load_low) else $error("buffer loaded while select low");

    property p_hs_pin;
        i_rst_n |=> (hs_pad_r.oe_n == ($past(mode_r) != MODE_1));
    endproperty
    a_hs_pin: assert property (p_hs_pin) else $error("sync pin direction wrong for mode");

    property p_osc_out;
        (mode_r == MODE_2) |=> (field_out_r == !$past(hs_pin));
    endproperty
    a_osc_out: assert property (p_osc_out) else $error("resonator output not inverted input");

    property p_marker_line;
        $rose(marker_r) |-> ($past(line_r) == target_line($past(mode_r)));
    endproperty
    a_marker_line: assert property (p_marker_line) else $error("marker on wrong line");

    property p_even_capture;
        ((cap_r == CAP_PUSH) && ((mode_r == MODE_1) || (mode_r == MODE_2))) |-> field_even_r;
    endproperty
    a_even_capture: assert property (p_even_capture) else $error("odd field captured in mode 1 or 2");

    property p_capture_line;
        (cap_r == CAP_IDLE) ##1 (cap_r == CAP_SAMPLE) |-> (line_r == target_line(mode_r));
    endproperty
    a_capture_line: assert property (p_capture_line) else $error("capture started off target line");

    property p_ref_div;
        osc_ref |-> (div_r == 5'h1F) && (mode_r == MODE_2);
    endproperty
    a_ref_div: assert property (p_ref_div) else $error("resonator reference not every 32nd edge");

endmodule
`default_nettype wire

// *** cclx_decoder.sv ***
// decoder-side partner: frames one 16-clock caption read per request
// assumes the caption line is pulled up outside the block
`timescale 1ns/10ps
`default_nettype none

module cclx_decoder
(
    input wire logic i_mclk,
    input wire logic i_start,
    input wire logic i_slow,
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_cs_n,
    output logic [15:0] o_word,
    output logic o_done
);
    task automatic rd;
        int h;
        h = i_slow ? 30 : 10;
        o_cs_n <= 1'h0;
        repeat (20) @(posedge i_mclk);
        for (int i = 0; i < 16; i++)
        begin
            repeat (h) @(posedge i_mclk);
            // bit sampled before the fall that replaces it
            o_word[i] <= i_sdo;
            o_sclk <= 1'h0;
            repeat (h) @(posedge i_mclk);
            o_sclk <= 1'h1;
        end
        repeat (h) @(posedge i_mclk);
        o_cs_n <= 1'h1;
        o_done <= 1'h1;
        @(posedge i_mclk);
        o_done <= 1'h0;
    endtask

    // clock parks high between frames
    initial
    begin
        o_sclk = 1'h1;
        o_cs_n = 1'h1;
        o_word = 16'h0000;
        o_done = 1'h0;
        forever
        begin
            @(posedge i_mclk);
            if (i_start) rd();
        end
    end
endmodule

`default_nettype wire

// *** tb.sv ***
// self-checking bench: video lines, decoder reads, mode straps, shared pins
// assumes the design's own assertions run alongside
`timescale 1ns/10ps
`default_nettype none
`include "cclx_regs.svh"

module tb
    import cclx_pkg::*;
;
    localparam int LN = `CCLX_LINE_CYC;
    localparam int FB = `CCLX_FIRST_BIT_CYC - 14;
    localparam int BT = `CCLX_BIT_CYC;
    logic i_mclk = 1'h0, rst_n = 1'h0, s_lo = 1'h0, s_hi = 1'h0, sync_n = 1'h1;
    logic slice = 1'h0, hs = 1'h1, st = 1'h0, slow = 1'h0;
    logic sclk, cs_n, dn, fld, mk;
    logic [15:0] dw, w;
    cclx_pad_t hpad, cpad;
    int fails = 0, check_count = 0, cyc = 0;
    logic [15:0] rq[$];
    // open-drain line with pull-up
    wire logic sdo = cpad.oe_n ? 1'h1 : cpad.o;

    cclx_top cclx_top_i (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_mode_strap_low(s_lo),
        .i_mode_strap_high(s_hi), .i_composite_video_in_sync_n(sync_n),
        .i_composite_video_in_slice(slice), .i_hsync_or_osc_in(hs), .o_hsync_or_osc_in_pad(hpad),
        .o_field_parity_or_osc_out(fld), .o_line_marker_pulse(mk), .i_transfer_clock_in(sclk),
        .i_chip_select_n(cs_n), .o_caption_serial_out_pad(cpad));
    cclx_decoder cclx_decoder_i (.i_mclk(i_mclk), .i_start(st), .i_slow(slow), .i_sdo(sdo),
        .o_sclk(sclk), .o_cs_n(cs_n), .o_word(dw), .o_done(dn));

    initial
    begin
        forever #25 i_mclk = ~i_mclk;
    end

    task cmp(input logic [15:0] g, input logic [15:0] e, input string m);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask

    task summarize;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // video: v 1 odd / 2 even broad pulse, d 1 target line / 2 line after
    // ----------------------------------------------------------------------
    task line(input int v, input int dl, input int m);
        int p;
        for (int c = 0; c < LN; c++)
        begin
            @(posedge i_mclk);
            p = c + (dl == 2 ? LN : 0);
            sync_n <= !(c < 94 || (v == 1 && c < 410) || (v == 2 && c >= 700 && c < 1110));
            hs <= !(c < 94);
            slice <= (dl > 0 && p >= FB && p < FB + 16 * BT) ? w[(p - FB) / BT] : 1'h0;
            if (c == 600 && m >= 0) cmp(16'(mk), 16'(m), "marker");
            if (c == 50 && m >= 0) cmp(16'(hpad.o), 16'(s_lo | s_hi), "hsync pad level");
        end
    endtask

    task field(input int v, input int m);
        w = 16'($urandom);
        line(v, 0, -1);
        repeat (16) line(0, 0, 0);
        line(0, 1, m);
        line(0, 2, 0);
    endtask

    // read queued first so the watcher has the note before the word lands
    task rd(input logic [15:0] e, input logic s);
        rq.push_back(e);
        slow <= s;
        st <= 1'h1;
        @(posedge i_mclk);
        st <= 1'h0;
        for (int k = 0; k < 3000 && dn !== 1'h1; k++) @(negedge i_mclk);
        if (dn !== 1'h1) cmp(16'(dn), 16'h0001, "read timed out");
        repeat (6) @(negedge i_mclk);
        cmp(16'(cpad.oe_n), 16'h0001, "line not released");
    endtask

    always @(posedge i_mclk)
    begin
        cyc++;
        if (dn === 1'h1) cmp(dw, rq.pop_front(), "read word");
        if (cyc == 90000)
        begin
            fails++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(53));
        repeat (4) @(posedge i_mclk);
        rst_n <= 1'h1;
        repeat (4) @(posedge i_mclk);
        field(2, 1);
        cmp(16'(fld), 16'h0001, "field flag even");
        rd(w, 1'h0);
        rd(16'h0000, 1'h1);
        cmp(16'(hpad.oe_n), 16'h0000, "hsync pad mode 1");
        $display("end mode 1 even");
        field(1, 0);
        cmp(16'(fld), 16'h0000, "field flag odd");
        rd(16'h0000, 1'h0);
        $display("end mode 1 odd");
        s_hi <= 1'h1;
        field(1, 1);
        rd(w, 1'h1);
        cmp(16'(hpad.oe_n), 16'h0001, "hsync pad mode 3");
        $display("end mode 3 odd");
        // resonator on the shared pin; the field pin echoes it inverted
        s_hi <= 1'h0;
        s_lo <= 1'h1;
        for (int i = 0; i < 80; i++)
        begin
            @(posedge i_mclk);
            hs <= ~hs;
            repeat (8) @(posedge i_mclk);
            cmp(16'(fld), 16'(!hs), "resonator echo");
        end
        cmp(16'(hpad.oe_n), 16'h0001, "hsync pad mode 2");
        $display("end mode 2");
        summarize();
    end
endmodule

`default_nettype wire
